// file: core/phy_status_pkg.sv
// Package: offsets, field layouts, reset values and timing for the PHY status block
package phy_status_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_BASIC_CTRL  = 8'h00;
   localparam logic [7:0] OFS_BASIC_STAT  = 8'h04;
   localparam logic [7:0] OFS_ADVERT      = 8'h08;
   localparam logic [7:0] OFS_GIG_CTRL    = 8'h0C;
   localparam logic [7:0] OFS_MS_STAT     = 8'h10;
   localparam logic [7:0] OFS_MODE_CTRL   = 8'h14;
   localparam logic [7:0] OFS_SPEED_STAT  = 8'h18;
   localparam logic [7:0] OFS_LINK_CTRL   = 8'h1C;
   localparam logic [7:0] OFS_EXPANSION   = 8'h20;
   localparam logic [7:0] OFS_EVENT_STAT  = 8'h24;
   // Basic control field positions
   localparam int BC_RESET = 15;
   localparam int BC_ANEN  = 12;
   localparam int BC_ISO   = 10;
   localparam int BC_DUPLEX = 8;
   // Basic status positions
   localparam int BS_LINK  = 2;
   localparam int BS_ANC   = 5;
   // Master/slave status positions
   localparam int MS_FAULT = 15;
   localparam int MS_LOCAL = 13;
   localparam int MS_REMOTE = 12;
   // Mode field position
   localparam int MODE_LSB = 11;
   // Link control fields
   localparam int LC_EN    = 15;
   localparam int LC_THR_LSB = 0;
   // Operating-mode codes
   localparam logic [4:0] MODE_AUTO_SINGLE = 5'h17;
   localparam logic [4:0] MODE_AUTO_MULTI  = 5'h18;
   localparam logic [4:0] MODE_MAN_SLAVE   = 5'h19;
   localparam logic [4:0] MODE_MAN_MASTER  = 5'h1A;
   // Gigabit control presets, bits 12..8
   localparam logic [4:0] GIG_AUTO_SINGLE = 5'h03;
   localparam logic [4:0] GIG_AUTO_MULTI  = 5'h0F;
   localparam logic [4:0] GIG_MAN_SLAVE   = 5'h13;
   localparam logic [4:0] GIG_MAN_MASTER  = 5'h1F;
   localparam logic [3:0] ADV_PRESET      = 4'hF;
   // Strap levels
   localparam logic [1:0] STRAP_GND  = 2'h0;
   localparam logic [1:0] STRAP_FAST = 2'h1;
   localparam logic [1:0] STRAP_GIG  = 2'h2;
   localparam logic [1:0] STRAP_VDD  = 2'h3;
   // Resolved speed encodings
   localparam logic [1:0] SPD_10   = 2'h0;
   localparam logic [1:0] SPD_100  = 2'h1;
   localparam logic [1:0] SPD_1000 = 2'h2;
   // Timing
   localparam int CLK_HZ      = 10_000_000;
   localparam int BLINK_MS    = 40;
   localparam int BLINK_CYC   = CLK_HZ / 1000 * BLINK_MS;
   localparam int BER_WIN_US  = 1000;
   localparam int BER_WIN_CYC = CLK_HZ / 1_000_000 * BER_WIN_US;
endpackage

// file: core/phy_mode_link_status_logic.sv
// PHY mode decode, lamps, isolate, carrier sense and link status with AXI4-Lite registers
//
// Decided for this implementation: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module phy_mode_link_status_logic
   import phy_status_pkg::*;
#(
   parameter int BLINK_CYCLES = BLINK_CYC,
   parameter int BER_CYCLES   = BER_WIN_CYC
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Strap levels, already decoded from pins
   input  wire logic [1:0]  mode_strap_high,
   input  wire logic [1:0]  mode_strap_low,
   // MAC side
   input  wire logic [7:0]  txd_in,
   input  wire logic        tx_control_in,
   output logic [7:0]       txd_path,
   output logic             tx_en_path,
   output logic             rx_control_out,
   // Receive symbol stream (encoded, unscrambled), one bit per clock
   input  wire logic        rx_bit,
   input  wire logic        sym_ssd,
   input  wire logic        sym_t,
   input  wire logic        sym_r,
   input  wire logic        sym_idle,
   input  wire logic        sym_valid,
   input  wire logic        rx_err_idle,
   input  wire logic        rx_packet,
   // Negotiation and partner
   input  wire logic        an_done,
   input  wire logic        an_fail,
   input  wire logic [1:0]  an_speed,
   input  wire logic        lp_ms_manual,
   input  wire logic        lp_ms_value,
   input  wire logic        local_trained,
   input  wire logic        remote_trained,
   input  wire logic        link_ok_lower,
   input  wire logic        repeater_mode,
   // Lamps
   output logic             gig_speed_lamp,
   output logic             fast_speed_lamp,
   output logic             base_speed_lamp
);
   // Refuse cycle counts the timers cannot serve
   if (BLINK_CYCLES < 2 || BER_CYCLES < 2) begin : g_bad_cycles
      $error("cycle parameters must be at least two");
   end

   // Synchronise off-domain inputs
   logic [1:0] sh_s1_r, sh_s2_r, sl_s1_r, sl_s2_r;
   logic [11:0] in_s1_r, in_s2_r;
   always_ff @(posedge aclk) begin
      sh_s1_r <= mode_strap_high;
      sh_s2_r <= sh_s1_r;
      sl_s1_r <= mode_strap_low;
      sl_s2_r <= sl_s1_r;
      in_s1_r <= {rx_bit, sym_ssd, sym_t, sym_r, sym_idle, sym_valid, rx_err_idle,
                  rx_packet, link_ok_lower, local_trained, remote_trained, tx_control_in};
      in_s2_r <= in_s1_r;
   end
   wire rxb   = in_s2_r[11];
   wire s_ssd = in_s2_r[10];
   wire s_t   = in_s2_r[9];
   wire s_r   = in_s2_r[8];
   wire s_idl = in_s2_r[7];
   wire s_val = in_s2_r[6];
   wire s_err = in_s2_r[5];
   wire s_pkt = in_s2_r[4];
   wire s_lok = in_s2_r[3];
   wire s_ltr = in_s2_r[2];
   wire s_rtr = in_s2_r[1];
   wire s_txc = in_s2_r[0];

   // Registers
   logic [15:0] bctrl_r, advert_r, gig_r, link_ctrl_r;
   logic [4:0]  mode_r;
   logic [2:0]  load_cnt_r;
   logic        anc_r, pdf_r, msf_r, ev_anc_r, link_r, carrier_r;

   // Mode presets from the latched mode field
   logic [4:0] gig_preset;
   logic       mode_ok;
   always_comb begin
      mode_ok = 1'b1;
      case (mode_r)
         MODE_AUTO_SINGLE: gig_preset = GIG_AUTO_SINGLE;
         MODE_AUTO_MULTI:  gig_preset = GIG_AUTO_MULTI;
         MODE_MAN_SLAVE:   gig_preset = GIG_MAN_SLAVE;
         MODE_MAN_MASTER:  gig_preset = GIG_MAN_MASTER;
         default: begin
            gig_preset = 5'h00;
            mode_ok    = 1'b0;
         end
      endcase
   end
   wire [4:0] strap_mode = (sh_s2_r == STRAP_GIG) ?
                           5'(MODE_AUTO_SINGLE + {3'h0, sl_s2_r}) : 5'h00;

   // AXI handshakes
   logic aw_ok_r, w_ok_r;
   logic [7:0] awaddr_r;
   logic [15:0] wdata_r;
   assign s_axi_awready = !aw_ok_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_ok_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   wire do_wr = aw_ok_r && w_ok_r && !s_axi_bvalid;
   wire wr_bc = do_wr && awaddr_r == OFS_BASIC_CTRL;
   wire wr_ad = do_wr && awaddr_r == OFS_ADVERT;
   wire wr_gc = do_wr && awaddr_r == OFS_GIG_CTRL;
   wire wr_md = do_wr && awaddr_r == OFS_MODE_CTRL;
   wire wr_lc = do_wr && awaddr_r == OFS_LINK_CTRL;
   wire wr_ev = do_wr && awaddr_r == OFS_EVENT_STAT;
   wire wr_map = wr_bc | wr_ad | wr_gc | wr_md | wr_lc | wr_ev;
   wire sw_rst = wr_bc && wdata_r[BC_RESET];
   wire rd_ev = s_axi_arvalid && s_axi_arready && s_axi_araddr == OFS_EVENT_STAT;

   // Write capture and response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_ok_r <= 1'b0;
         w_ok_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 16'h0000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_ok_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_ok_r <= 1'b1;
            wdata_r <= s_axi_wdata[15:0];
         end
         if (do_wr) begin
            aw_ok_r <= 1'b0;
            w_ok_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_map ? 2'h0 : 2'h2;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Control registers; straps load a few cycles after hw reset release only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         load_cnt_r <= 3'h0;
         mode_r <= 5'h00;
         bctrl_r <= 16'h0000;
         advert_r <= 16'h0000;
         gig_r <= 16'h0000;
         link_ctrl_r <= 16'h0000;
      end else if (load_cnt_r < 3'h4) begin
         load_cnt_r <= 3'(load_cnt_r + 3'h1);
         if (load_cnt_r == 3'h3) begin
            mode_r <= strap_mode;
         end
      end else if (load_cnt_r == 3'h4) begin
         // One-shot preset, so later register writes, soft reset included, never re-run it
         load_cnt_r <= 3'h5;
         bctrl_r[13] <= 1'b0;
         bctrl_r[BC_ANEN] <= mode_ok;
         bctrl_r[6] <= mode_ok;
         advert_r[8:5] <= mode_ok ? ADV_PRESET : 4'h0;
         gig_r[12:8] <= gig_preset;
         mode_r <= mode_ok ? mode_r : 5'h00;
      end else begin
         if (wr_bc) bctrl_r <= {1'b0, wdata_r[14:0]};
         if (wr_ad) advert_r <= wdata_r;
         if (wr_gc) gig_r <= wdata_r;
         if (wr_md) mode_r <= wdata_r[15:11];
         if (wr_lc) link_ctrl_r <= wdata_r;
      end
   end
   wire isolate = bctrl_r[BC_ISO];
   wire full_dup = bctrl_r[BC_DUPLEX];

   // Isolate gates transmit path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         txd_path <= 8'h00;
         tx_en_path <= 1'b0;
      end else begin
         txd_path <= isolate ? 8'h00 : txd_in;
         tx_en_path <= !isolate && s_txc;
      end
   end

   // Carrier detect over the bit stream
   typedef enum logic [1:0] {CS_IDLE, CS_PRE, CS_STREAM, CS_END} cs_e;
   cs_e cs_r;
   logic [9:0] win_r;
   logic [3:0] ones_r;
   logic       prev_idle_r;
   wire [9:0] win_nxt = {win_r[8:0], rxb};
   wire [3:0] zeros = 4'($countones(~win_nxt));
   wire two_sep = zeros >= 4'h3 || (zeros == 4'h2 && (~win_nxt & (~win_nxt >> 1)) == 10'h000);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cs_r <= CS_IDLE;
         win_r <= 10'h3FF;
         ones_r <= 4'h0;
         carrier_r <= 1'b0;
         prev_idle_r <= 1'b0;
      end else begin
         win_r <= win_nxt;
         ones_r <= rxb ? ((ones_r == 4'hA) ? ones_r : 4'(ones_r + 4'h1)) : 4'h0;
         prev_idle_r <= s_idl;
         case (cs_r)
            CS_IDLE: if (two_sep) begin
               cs_r <= CS_PRE;
               carrier_r <= 1'b1;
            end
            CS_PRE: if (s_ssd) begin
               cs_r <= CS_STREAM;
            end else if (ones_r == 4'h9 && rxb) begin
               cs_r <= CS_IDLE;
               carrier_r <= 1'b0;
            end
            CS_STREAM: if (s_t || s_idl) begin
               cs_r <= CS_END;
            end
            CS_END: if ((prev_idle_r && s_idl) || s_r) begin
               cs_r <= CS_IDLE;
               carrier_r <= 1'b0;
            end else begin
               cs_r <= CS_STREAM;
            end
            default: cs_r <= CS_IDLE;
         endcase
      end
   end
   assign rx_control_out = carrier_r || (!(full_dup || repeater_mode) && tx_en_path);

   // Link, faults and speed
   wire ms_both_manual = gig_r[12] && lp_ms_manual;
   wire ms_clash = ms_both_manual && (gig_r[11] == lp_ms_value);
   logic [15:0] ber_cnt_r;
   logic [31:0] win_cnt_r;
   logic        ber_trip_r;
   wire gig = an_speed == SPD_1000;
   wire link_nxt = s_lok && (!gig || (s_ltr && s_rtr && s_val)) && !ber_trip_r;
   always_ff @(posedge aclk) begin
      if (!aresetn || sw_rst) begin
         link_r <= 1'b0;
         anc_r <= 1'b0;
         pdf_r <= 1'b0;
         msf_r <= 1'b0;
         ev_anc_r <= 1'b0;
         ber_cnt_r <= 16'h0000;
         win_cnt_r <= 32'h0;
         ber_trip_r <= 1'b0;
      end else begin
         link_r <= link_nxt;
         anc_r <= an_done;
         if (an_done && !anc_r) ev_anc_r <= 1'b1;
         else if (rd_ev) ev_anc_r <= 1'b0;
         if (an_fail && !gig) pdf_r <= 1'b1;
         if ((an_fail && gig) || ms_clash) msf_r <= 1'b1;
         if (!link_ctrl_r[LC_EN] || !gig || !link_r) begin
            win_cnt_r <= 32'h0;
            ber_cnt_r <= 16'h0000;
         end else if (win_cnt_r == 32'(BER_CYCLES - 1)) begin
            win_cnt_r <= 32'h0;
            ber_cnt_r <= 16'h0000;
            ber_trip_r <= ber_cnt_r > {4'h0, link_ctrl_r[11:0]};
         end else begin
            win_cnt_r <= 32'(win_cnt_r + 32'h1);
            if (s_err) ber_cnt_r <= 16'(ber_cnt_r + 16'h1);
         end
      end
   end

   // Activity blink timer
   logic [31:0] blink_cnt_r;
   logic        blink_on_r, blink_ph_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         blink_cnt_r <= 32'h0;
         blink_on_r <= 1'b0;
         blink_ph_r <= 1'b0;
      end else if (s_pkt || (tx_en_path && !blink_on_r)) begin
         blink_cnt_r <= 32'h0;
         blink_on_r <= 1'b1;
         blink_ph_r <= 1'b0;
      end else if (blink_on_r) begin
         if (blink_cnt_r == 32'(BLINK_CYCLES - 1)) begin
            blink_cnt_r <= 32'h0;
            blink_ph_r <= ~blink_ph_r;
            blink_on_r <= blink_ph_r ? 1'b0 : 1'b1;
         end else begin
            blink_cnt_r <= 32'(blink_cnt_r + 32'h1);
         end
      end
   end
   wire lamp_lvl = link_r && !(blink_on_r && blink_ph_r);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gig_speed_lamp <= 1'b0;
         fast_speed_lamp <= 1'b0;
         base_speed_lamp <= 1'b0;
      end else begin
         gig_speed_lamp <= lamp_lvl && an_speed == SPD_1000;
         fast_speed_lamp <= lamp_lvl && an_speed == SPD_100;
         base_speed_lamp <= lamp_lvl && an_speed == SPD_10;
      end
   end

   // Read mux
   logic [15:0] rd_val;
   always_comb begin
      case (s_axi_araddr)
         OFS_BASIC_CTRL: rd_val = bctrl_r;
         OFS_BASIC_STAT: rd_val = {10'h000, anc_r, 2'h0, link_r, 2'h0};
         OFS_ADVERT:     rd_val = advert_r;
         OFS_GIG_CTRL:   rd_val = gig_r;
         OFS_MS_STAT:    rd_val = {msf_r, 1'b0, s_ltr, s_rtr, 12'h000};
         OFS_MODE_CTRL:  rd_val = {mode_r, 11'h000};
         OFS_SPEED_STAT: rd_val = {14'h0000, an_speed};
         OFS_LINK_CTRL:  rd_val = link_ctrl_r;
         OFS_EXPANSION:  rd_val = {11'h000, pdf_r, 4'h0};
         OFS_EVENT_STAT: rd_val = {15'h0000, ev_anc_r};
         default:        rd_val = 16'h0000;
      endcase
   end
   wire rd_hit = s_axi_araddr <= OFS_EVENT_STAT && s_axi_araddr[1:0] == 2'h0;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= {16'h0000, rd_val};
         s_axi_rresp <= rd_hit ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: tb/phy_link_partner.sv
// Remote link partner model: receive code-group stream and training state
`timescale 1ns/1ps
`default_nettype none
module phy_link_partner (
   input  wire logic go,
   input  wire logic aclk,
   output logic      rx_bit,
   output logic      sym_ssd,
   output logic      sym_t,
   output logic      sym_r,
   output logic      sym_idle,
   output logic      sym_valid,
   output logic      rx_packet,
   output logic      remote_trained
);
   logic [5:0] step_r = 6'h00;
   wire        in_data = step_r > 6'h05 && step_r < 6'h18;
   // Frame: two lone zeros, start pair, data, end pair, then idles
   always_ff @(posedge aclk) begin
      step_r         <= (go || step_r != 6'h00) ? step_r + 6'h01 : 6'h00;
      rx_bit         <= !(step_r == 6'h01 || step_r == 6'h03 || (in_data && step_r[0]));
      sym_ssd        <= step_r == 6'h05;
      sym_valid      <= 1'b1;
      rx_packet      <= step_r == 6'h06;
      sym_t          <= step_r == 6'h18;
      sym_r          <= step_r == 6'h19;
      sym_idle       <= step_r == 6'h00 || step_r > 6'h1A;
      remote_trained <= 1'b1;
   end
endmodule
`default_nettype wire

// file: tb/phy_mode_link_status_logic_asserts.sv
// Bus timing and output relation checks for the PHY status block
`timescale 1ns/1ps
`default_nettype none
module phy_status_asserts (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        tx_control_in,
   input wire logic        tx_en_path,
   input wire logic        gig_speed_lamp,
   input wire logic        fast_speed_lamp,
   input wire logic        base_speed_lamp
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // At most one speed lamp for the resolved speed
   property p_lamp_one; $onehot0({gig_speed_lamp, fast_speed_lamp, base_speed_lamp}); endproperty
   a_lamp_one: assert property (p_lamp_one) else $error("two speed lamps lit");
   // Transmit enable only follows a request seen through the synchroniser
   property p_tx_src; tx_en_path |-> $past(tx_control_in, 3); endproperty
   a_tx_src: assert property (p_tx_src) else $error("tx enable without request");
   // Write answer two cycles after joint handshake
   property p_b_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
   a_b_lat: assert property (p_b_lat) else $error("write answer late");
   // Read answer one cycle after address
   property p_r_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_r_lat: assert property (p_r_lat) else $error("read answer late");
   // New write address refused while answer pending
   property p_aw_hold; s_axi_bvalid |-> !s_axi_awready; endproperty
   a_aw_hold: assert property (p_aw_hold) else $error("write taken during answer");
   // Unmapped read gives error and zero data
   property p_unmap; s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h3C |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
   // Registers are sixteen bits wide
   property p_upper; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0; endproperty
   a_upper: assert property (p_upper) else $error("upper read bits set");
   // Answer drops once taken
   property p_b_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   a_b_drop: assert property (p_b_drop) else $error("write answer repeated");
endmodule
bind phy_mode_link_status_logic phy_status_asserts u_chk (.*);
`default_nettype wire

// file: tb/phy_mode_link_status_logic_tb_top.sv
// Self-checking bench for mode presets, isolate, carrier sense and link lamps
`timescale 1ns/1ps
`default_nettype none
module phy_mode_link_status_logic_tb_top;
   import phy_status_pkg::*;
   logic        aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, txd_in = 8'h00, txd_path;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [1:0]  s_axi_bresp, s_axi_rresp, an_speed = 2'h0, lo, rbase;
   logic [1:0]  mode_strap_high = STRAP_GIG, mode_strap_low = STRAP_GND;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, tx_control_in = 1'b0;
   logic        an_done = 1'b0, an_fail = 1'b0, lp_ms_manual = 1'b0, lp_ms_value = 1'b0;
   logic        local_trained = 1'b1, link_ok_lower = 1'b0, repeater_mode = 1'b0;
   logic        rx_err_idle = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid, tx_en_path, rx_control_out;
   logic        gig_speed_lamp, fast_speed_lamp, base_speed_lamp;
   logic        rx_bit, sym_ssd, sym_t, sym_r, sym_idle, sym_valid, rx_packet, remote_trained;
   logic [65:0] exp_q [$];
   logic [65:0] note;
   logic [4:0]  gig_tab [4] = '{GIG_AUTO_SINGLE, GIG_AUTO_MULTI, GIG_MAN_SLAVE, GIG_MAN_MASTER};
   int          seed = 32'h5abbfee2;
   int          mismatches = 0;
   int          checked = 0;
   wire [2:0]   lamps = {gig_speed_lamp, fast_speed_lamp, base_speed_lamp};

   phy_mode_link_status_logic #(.BLINK_CYCLES(8), .BER_CYCLES(16)) u_dut (.*);
   phy_link_partner u_partner (.*);

   // Clock and hang guard
   always #50 aclk = ~aclk;
   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      close_out();
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      checked++;
      if (seen !== want) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, want);
      end
   endtask

   task automatic close_out;
      $display("checks=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic hw_reset(input logic [1:0] low);
      aresetn <= 1'b0;
      mode_strap_low <= low;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (8) @(posedge aclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
   endtask

   // Read: note expected data, mask and response for the monitor
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                     input logic [1:0] rs);
      exp_q.push_back({rs, m, e});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
   endtask

   // Wait bounded for carrier and lamps to reach a value
   task automatic settle(input logic [3:0] want);
      int n;
      n = 0;
      while ({rx_control_out, lamps} !== want && n < 80) begin
         @(posedge aclk);
         n++;
      end
      chk({rx_control_out, lamps}, want);
   endtask

   // Monitor: compare each read answer against the oldest note
   always @(posedge aclk) begin
      if (s_axi_rvalid && s_axi_rready && exp_q.size() > 0) begin
         note = exp_q.pop_front();
         chk(s_axi_rdata & note[63:32], note[31:0]);
         chk(s_axi_rresp, note[65:64]);
      end
   end

   initial begin
      rbase = 2'($random(seed));
      for (int i = 0; i < 4; i++) begin
         lo = rbase ^ 2'(i);
         hw_reset(lo);
         rd(OFS_MODE_CTRL, {16'h0, MODE_AUTO_SINGLE + 5'(lo), 11'h0}, 32'hF800, 2'h0);
         rd(OFS_BASIC_CTRL, 32'h1040, 32'h3440, 2'h0);
         rd(OFS_ADVERT, {23'h0, ADV_PRESET, 5'h0}, 32'h1E0, 2'h0);
         rd(OFS_GIG_CTRL, {19'h0, gig_tab[lo], 8'h0}, 32'h1F00, 2'h0);
      end
      mode_strap_low <= ~lo;
      wr(OFS_BASIC_CTRL, 32'h9040);
      repeat (8) @(posedge aclk);
      rd(OFS_MODE_CTRL, {16'h0, MODE_AUTO_SINGLE + 5'(lo), 11'h0}, 32'hF800, 2'h0);
      mode_strap_high <= STRAP_VDD;
      hw_reset(lo);
      rd(OFS_MODE_CTRL, 32'h0, 32'hF800, 2'h0);
      mode_strap_high <= STRAP_GIG;
      hw_reset(rbase);
      rd(8'h3C, 32'h0, 32'hFFFFFFFF, 2'h2);
      // Transmit path, isolate and duplex-dependent carrier
      wr(OFS_BASIC_CTRL, 32'h1040);
      tx_control_in <= 1'b1;
      txd_in <= 8'($random(seed));
      repeat (4) @(posedge aclk);
      chk({tx_en_path, txd_path}, {1'b1, txd_in});
      settle(4'h8);
      wr(OFS_BASIC_CTRL, 32'h1440);
      repeat (3) @(posedge aclk);
      chk({tx_en_path, txd_path}, 9'h0);
      rd(OFS_BASIC_CTRL, 32'h0400, 32'h0400, 2'h0);
      wr(OFS_BASIC_CTRL, 32'h1140);
      repeat (3) @(posedge aclk);
      chk(rx_control_out, 1'b0);
      wr(OFS_BASIC_CTRL, 32'h1040);
      repeater_mode <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(rx_control_out, 1'b0);
      repeater_mode <= 1'b0;
      tx_control_in <= 1'b0;
      wr(OFS_BASIC_CTRL, 32'h1040);
      // Received frame raises and then removes carrier
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      settle(4'h8);
      repeat (12) @(posedge aclk);
      chk(rx_control_out, 1'b1);
      settle(4'h0);
      // Link at each speed: lamp, status, speed and event
      for (int s = 0; s < 3; s++) begin
         an_speed <= 2'(s);
         an_done <= 1'b1;
         link_ok_lower <= 1'b1;
         settle({1'b0, 3'h1 << s});
         rd(OFS_BASIC_STAT, 32'h24, 32'h24, 2'h0);
         rd(OFS_SPEED_STAT, 32'(s), 32'h3, 2'h0);
         rd(OFS_EVENT_STAT, 32'h1, 32'h1, 2'h0);
         rd(OFS_EVENT_STAT, 32'h0, 32'h1, 2'h0);
         if (s == 2) begin
            rd(OFS_MS_STAT, 32'h3000, 32'h3000, 2'h0);
            wr(OFS_LINK_CTRL, 32'h8000);
            rx_err_idle <= 1'b1;
            settle(4'h0);
            rx_err_idle <= 1'b0;
         end
         an_done <= 1'b0;
         link_ok_lower <= 1'b0;
         settle(4'h0);
      end
      // Negotiation failures with conflicting manual settings
      wr(OFS_GIG_CTRL, 32'h1800);
      lp_ms_manual <= 1'b1;
      lp_ms_value <= 1'b1;
      an_speed <= SPD_1000;
      an_fail <= 1'b1;
      repeat (4) @(posedge aclk);
      rd(OFS_MS_STAT, 32'h8000, 32'h8000, 2'h0);
      an_speed <= SPD_100;
      wr(OFS_BASIC_CTRL, 32'h9040);
      repeat (4) @(posedge aclk);
      rd(OFS_EXPANSION, 32'h10, 32'h10, 2'h0);
      repeat (4) @(posedge aclk);
      chk(32'(exp_q.size()), 32'h0);
      close_out();
   end
endmodule
`default_nettype wire
